// file: rtl/uwsc_counter.sv
// up/down wiper step counter for a 64-tap resistor ladder
// assumes pins are asynchronous to clk_sys and debounced by the host
`timescale 1ns/1ps
`default_nettype none
module uwsc_counter (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire uwsc_pkg::uwsc_pins_t pins,
  output uwsc_pkg::uwsc_taps_t taps
);
  import uwsc_pkg::*;

  // rstn clears every flop at once; its release is retimed so that
  // no group leaves reset a cycle ahead of its neighbours
  logic [1:0] rst_sync_reg;
  logic [1:0] rst_sync_next;
  logic rst_n_int;

  always_comb begin
    rst_sync_next = {rst_sync_reg[0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= RST_SYNC_INIT;
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  // a step edge that qualifies while reset is released may be missed
  assign rst_n_int = rst_sync_reg[1];

  // a level that toggles faster than the stages can agree is never
  // qualified, so pulses shorter than two cycles are lost
  logic [N_PINS-1:0] pin_raw;
  wire logic [N_PINS-1:0] pin_qual;
  wire logic [N_PINS-1:0] pin_qual_nx;

  assign pin_raw = pins;

  // one three-flop synchroniser per control pin
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_sync
      uwsc_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n_int),
        .pin(pin_raw[gi]),
        .qual(pin_qual[gi]),
        .qual_nx(pin_qual_nx[gi])
      );
    end
  endgenerate

  // qualified controls; select and direction are the levels that
  // stand as the step edge qualifies, so all three keep pin timing
  uwsc_pins_t ctl_now;
  uwsc_pins_t ctl_nx;
  logic fall;

  always_comb begin
    ctl_now = pin_qual;
    ctl_nx = pin_qual_nx;
  end

  // falling step edge, seen on the clock edge at which it qualifies
  always_comb begin
    fall = ctl_now.step_clk && !ctl_nx.step_clk;
  end

  // true when the counter already sits at the end it is heading for
  function automatic logic at_end(
    input logic [POS_W-1:0] p,
    input logic u
  );
    logic r;
    if (u) begin
      r = p == POS_MAX;
    end else begin
      r = p == POS_MIN;
    end
    return r;
  endfunction

  // one step up or down; saturates at either end, never wraps
  function automatic logic [POS_W-1:0] step_once(
    input logic [POS_W-1:0] p,
    input logic u
  );
    logic [POS_W-1:0] r;
    case ({at_end(p, u), u})
      2'b01: begin
        r = p + POS_STEP;
      end
      2'b00: begin
        r = p - POS_STEP;
      end
      default: begin
        r = p;
      end
    endcase
    return r;
  endfunction

  // position counter: one step per qualified falling edge while selected
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;

  always_comb begin
    pos_next = pos_reg;
    if (fall && !ctl_now.chip_sel_n) begin
      pos_next = step_once(pos_reg, ctl_now.dir_up);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pos_reg <= POS_MID;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // wiper codes: registered so the outputs come straight from flops;
  // to-a is the complement of to-b on every edge
  uwsc_taps_t taps_reg;
  uwsc_taps_t taps_next;

  always_comb begin
    taps_next.wiper_to_b_resistance = pos_next;
    taps_next.wiper_to_a_resistance = POS_MAX - pos_next;
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      taps_reg.wiper_to_b_resistance <= POS_MID;
      taps_reg.wiper_to_a_resistance <= POS_MAX - POS_MID;
    end else begin
      taps_reg <= taps_next;
    end
  end

  // no readback path: the taps are the only outputs
  assign taps = taps_reg;
endmodule

// three-flop synchroniser with a settled-level qualifier for one pin;
// only the second stage reads the first
module uwsc_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  output logic qual,
  output logic qual_nx
);
  import uwsc_pkg::*;

  // stages 2 and 3 agreeing mean the pin level has settled
  function automatic logic stages_agree(
    input logic [2:0] s
  );
    return s[1] == s[2];
  endfunction

  // next qualified level: follows the pin only once it has settled
  function automatic logic qualify(
    input logic [2:0] s,
    input logic q
  );
    logic r;
    r = q;
    if (stages_agree(s)) begin
      r = s[2];
    end
    return r;
  endfunction

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic qual_reg;
  logic qual_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin};
    qual_next = qualify(stage_reg, qual_reg);
  end

  // idle high after reset, so no false step edge follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= SYNC_RST;
      qual_reg <= QUAL_RST;
    end else begin
      stage_reg <= stage_next;
      qual_reg <= qual_next;
    end
  end

  assign qual = qual_reg;
  assign qual_nx = qual_next;
endmodule
`default_nettype wire

// file: rtl/uwsc_pkg.sv
// package for the up/down wiper step counter
// assumes a single system clock domain; no software registers
package uwsc_pkg;
  localparam int POS_W = 6;
  localparam logic [5:0] POS_MID = 6'h20;
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] POS_MIN = 6'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
  localparam logic QUAL_RST = 1'b1;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [5:0] POS_STEP = 6'h01;
  localparam int N_PINS = 3;

  // three host-driven control pins
  typedef struct packed {
    logic step_clk;
    logic chip_sel_n;
    logic dir_up;
  } uwsc_pins_t;

  // complementary wiper codes: to-b rises as to-a falls
  typedef struct packed {
    logic [5:0] wiper_to_b_resistance;
    logic [5:0] wiper_to_a_resistance;
  } uwsc_taps_t;
endpackage

// file: verification/testbench.sv
// bench: host model steps the counter; taps compared after each step
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uwsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  uwsc_pins_t pins;
  uwsc_taps_t taps;
  int n_errors = 0;
  int checked = 0;
  always #2 clk_sys = ~clk_sys;
  uwsc_host u_host (.clk_sys(clk_sys), .pins(pins));
  uwsc_counter u_dut (.clk_sys(clk_sys), .rstn(rstn), .pins(pins),
    .taps(taps));
  task automatic expect_b(input logic [5:0] e);
    checked++;
    if ({taps} !== {e, POS_MAX - e}) begin
      n_errors++;
      $display("CHECK FAILED %0t taps %h", $time, taps);
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (8) @(negedge clk_sys);
    expect_b(POS_MID);
  endtask
  task automatic run(input logic cs_n, input logic up, input int n);
    logic [5:0] e;
    e = taps.wiper_to_b_resistance;
    repeat (n) begin
      u_host.step(cs_n, up);
      if (!cs_n && up && e != POS_MAX) e++;
      if (!cs_n && !up && e != POS_MIN) e--;
      expect_b(e);
    end
  endtask
  task automatic sc_climb_to_top();
    run(1'b0, 1'b1, 34);
  endtask
  task automatic sc_unselected();
    run(1'b1, 1'b0, 3);
  endtask
  task automatic sc_fall_to_bottom();
    run(1'b0, 1'b0, 66);
  endtask
  task automatic sc_two_up();
    run(1'b0, 1'b1, 2);
  endtask
  task automatic wrap_up();
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    do_reset();
    sc_climb_to_top();
    sc_unselected();
    sc_fall_to_bottom();
    sc_two_up();
    do_reset();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: verification/uwsc_host.sv
// host model: clean step pulses, drives the three pins at falling clk
`timescale 1ns/1ps
`default_nettype none
module uwsc_host (
  input wire logic clk_sys,
  output uwsc_pkg::uwsc_pins_t pins
);
  initial pins = 3'h6;
  task automatic step(input logic cs_n, input logic up);
    @(negedge clk_sys) {pins.chip_sel_n, pins.dir_up} = {cs_n, up};
    repeat (4) @(negedge clk_sys);
    pins.step_clk = 1'b0;
    repeat (4) @(negedge clk_sys);
    pins.step_clk = 1'b1;
    repeat (4) @(negedge clk_sys);
    pins.chip_sel_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verification/uwsc_properties.sv
// checker: tap codes against the pins; bound onto uwsc_counter
`timescale 1ns/1ps
`default_nettype none
module uwsc_properties (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire uwsc_pkg::uwsc_pins_t pins,
  input wire uwsc_pkg::uwsc_taps_t taps
);
  import uwsc_pkg::*;
  logic [5:0] b;
  assign b = taps.wiper_to_b_resistance;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_comp; taps.wiper_to_a_resistance == POS_MAX - b; endproperty
  a_comp: assert property (p_comp) else $error("a not b complement");
  property p_one; !$stable(b) |-> b - $past(b) inside {6'h01, 6'h3F};
  endproperty
  a_one: assert property (p_one) else $error("step not one");
  property p_cs; !$stable(b) |-> !$past(pins.chip_sel_n, 4); endproperty
  a_cs: assert property (p_cs) else $error("moved unselected");
  property p_edge; !$stable(b) |-> $past(pins.step_clk, 5) &&
    !$past(pins.step_clk, 3); endproperty
  a_edge: assert property (p_edge) else $error("not a falling edge");
  property p_sat; !($past(b) == POS_MAX && b == POS_MIN) &&
    !($past(b) == POS_MIN && b == POS_MAX); endproperty
  a_sat: assert property (p_sat) else $error("wrapped");
  property p_dir; !$stable(b) |->
    (b == $past(b) + 6'h01) == $past(pins.dir_up, 4); endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_mid; $rose(rstn) |-> b == POS_MID ##1 b == POS_MID; endproperty
  a_mid: assert property (p_mid) else $error("not midscale");
  property p_step; $fell(pins.step_clk) && !pins.chip_sel_n &&
    (pins.dir_up ? b != POS_MAX : b != POS_MIN) |-> ##[3:5] !$stable(b);
  endproperty
  a_step: assert property (p_step) else $error("step lost");
endmodule
bind uwsc_counter uwsc_properties u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .pins(pins), .taps(taps));
`default_nettype wire
